// File: common/adim_pkg.sv
package adim_pkg;
	localparam int IRQ_COUNT = 32;
	localparam int VEC_WIDTH = 16;
	localparam int NMI_SRC_WIDTH = 16;
	localparam int PRIO_WIDTH = 3;
	localparam logic [1:0] SYNC_LAT = 2'h3;
	// Vector bit positions
	localparam int VB_NMI = 0;
	localparam int VB_IPC0 = 1;
	localparam int VB_IPC1 = 2;
	localparam int VB_IPC2 = 3;
	localparam int VB_IPC3 = 4;
	localparam int VB_ATIM = 5;
	localparam int VB_SEC = 9;
	localparam int VB_STREAM = 10;
	localparam int VB_FCONV = 11;
	localparam int VB_USB = 12;
	localparam int VB_HDMI = 13;
	localparam int VB_DMA_S = 14;
	localparam int VB_DMA_NS = 15;
	// Interrupt IDs
	localparam int ID_NMI = 0;
	localparam int ID_SOFT = 1;
	localparam int ID_IPC0 = 2;
	localparam int ID_IPC1 = 3;
	localparam int ID_IPC2 = 4;
	localparam int ID_TIM0 = 5;
	localparam int ID_TIM1 = 6;
	localparam int ID_IPC3 = 7;
	localparam int ID_ATIM = 8;
	localparam int ID_SEC = 12;
	localparam int ID_STREAM = 13;
	localparam int ID_FCONV = 14;
	localparam int ID_USB = 15;
	localparam int ID_HDMI = 16;
	localparam int ID_DMA_S = 17;
	localparam int ID_DMA_NS = 18;
	// Priorities
	localparam logic [2:0] PRIO_NMI = 3'h6;
	localparam logic [2:0] PRIO_DEBUG = 3'h5;
	localparam logic [2:0] PRIO_TIM0 = 3'h3;
	localparam logic [2:0] PRIO_TIM1 = 3'h4;
	localparam logic [2:0] PRIO_IPC = 3'h3;
	localparam logic [2:0] PRIO_ATIM = 3'h2;
	localparam logic [2:0] PRIO_EXT1 = 3'h1;
	// Access size codes (AXI size)
	localparam logic [2:0] SIZE_8 = 3'h0;
	localparam logic [2:0] SIZE_16 = 3'h1;
	localparam logic [2:0] SIZE_32 = 3'h2;
	localparam logic [2:0] SIZE_64 = 3'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Memory layout
	localparam int MEM_WORDS = 64;
	localparam int MEM_AW = 6;
	localparam int ADDR_WIDTH = 16;
	localparam int DATA_BIT = 15;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_WRESP = 2'b11,
		ST_READ = 2'b10
	} adim_state_e;
endpackage

// File: design/adim_top.sv
`timescale 1ns/1ps
// How it works
// - Thirty-two interrupt lines feed the core, each with ID, type, priority
// - Non-maskable line is the OR of the sixteen NMI source bits
// - Debug interrupt at priority five, no ID, no vector bit
// - Internal timers go to IDs five and six, priorities three and four
// - Notifications 0,1 to IDs 2,3; 2,3 to IDs 4,7; level, priority three
// - Four audio timers to IDs eight to eleven, vector bits five to eight
// - Merged security interrupt to ID twelve, vector bit nine
// - Stream decoder interrupt to ID thirteen, vector bit ten
// - Frequency-conversion secure interrupt to ID fourteen, vector bit eleven
// - USB pair ORed to ID fifteen; HDMI pair ORed to ID sixteen
// - DMA secure to ID seventeen, non-secure to ID eighteen
// - Instruction memory takes only 32- and 64-bit accesses
// - Data memory takes 8, 16, 32 and 64-bit accesses
// - A 64-bit AXI slave reads and writes both local memories
module adim_top
	import adim_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Interrupt sources
	input wire logic [NMI_SRC_WIDTH-1:0] nmi_source_bits,
	input wire logic debugIrq,
	input wire logic softIrq,
	input wire logic timer0Irq,
	input wire logic timer1Irq,
	input wire logic [3:0] ipcIrq,
	input wire logic [3:0] audioTimerIrq,
	input wire logic [2:0] securityIrq,
	input wire logic streamIrq,
	input wire logic freqConvIrq,
	input wire logic usbAudioIrq,
	input wire logic usbCtrlIrq,
	input wire logic hdmiSecIrq,
	input wire logic hdmiNsIrq,
	input wire logic audio_dma_secure_irq,
	input wire logic audio_dma_nonsecure_irq,
	// Toward the core
	output logic [IRQ_COUNT-1:0] coreIrq,
	output logic coreDebugIrq,
	output logic [VEC_WIDTH-1:0] extVector,
	// AXI write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_WIDTH-1:0] awaddr,
	input wire logic [2:0] awsize,
	// AXI write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [63:0] wdata,
	input wire logic [7:0] wstrb,
	// AXI write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_WIDTH-1:0] araddr,
	input wire logic [2:0] arsize,
	// AXI read data
	output logic rvalid,
	input wire logic rready,
	output logic [63:0] rdata,
	output logic [1:0] rresp,
	output logic rlast
);
	function automatic logic accessOk(input logic [ADDR_WIDTH-1:0] a, input logic [2:0] s);
		logic isData;
		logic aligned;
		isData = a[DATA_BIT];
		case (s)
			SIZE_8: aligned = 1'b1;
			SIZE_16: aligned = ~a[0];
			SIZE_32: aligned = (a[1:0] == 2'h0);
			SIZE_64: aligned = (a[2:0] == 3'h0);
			default: aligned = 1'b0;
		endcase
		if (isData)
			accessOk = aligned && (s <= SIZE_64);
		else
			accessOk = aligned && (s == SIZE_32 || s == SIZE_64);
	endfunction

	logic [NMI_SRC_WIDTH-1:0] nmiMeta, nmiSync;
	logic [IRQ_COUNT-1:0] rawMeta, rawSync;
	logic dbgMeta, dbgSync;
	logic [IRQ_COUNT-1:0] rawIrq;
	logic nmiLevel;

	assign nmiLevel = |nmiSync;
	always_comb begin
		rawIrq = '0;
		rawIrq[ID_SOFT] = softIrq;
		rawIrq[ID_TIM0] = timer0Irq;
		rawIrq[ID_TIM1] = timer1Irq;
		rawIrq[ID_IPC0] = ipcIrq[0];
		rawIrq[ID_IPC1] = ipcIrq[1];
		rawIrq[ID_IPC2] = ipcIrq[2];
		rawIrq[ID_IPC3] = ipcIrq[3];
		rawIrq[ID_ATIM +: 4] = audioTimerIrq;
		rawIrq[ID_SEC] = |securityIrq;
		rawIrq[ID_STREAM] = streamIrq;
		rawIrq[ID_FCONV] = freqConvIrq;
		rawIrq[ID_USB] = usbAudioIrq | usbCtrlIrq;
		rawIrq[ID_HDMI] = hdmiSecIrq | hdmiNsIrq;
		rawIrq[ID_DMA_S] = audio_dma_secure_irq;
		rawIrq[ID_DMA_NS] = audio_dma_nonsecure_irq;
	end

	// Two-stage sync, then level outputs follow the sources
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nmiMeta <= '0;
			nmiSync <= '0;
			rawMeta <= '0;
			rawSync <= '0;
			dbgMeta <= 1'b0;
			dbgSync <= 1'b0;
		end else begin
			nmiMeta <= nmi_source_bits;
			nmiSync <= nmiMeta;
			rawMeta <= rawIrq;
			rawSync <= rawMeta;
			dbgMeta <= debugIrq;
			dbgSync <= dbgMeta;
		end
	end

	logic [IRQ_COUNT-1:0] next_coreIrq;
	logic [VEC_WIDTH-1:0] next_extVector;
	always_comb begin
		next_coreIrq = rawSync;
		next_coreIrq[ID_NMI] = nmiLevel;
		next_extVector = '0;
		next_extVector[VB_NMI] = nmiLevel;
		next_extVector[VB_IPC0] = rawSync[ID_IPC0];
		next_extVector[VB_IPC1] = rawSync[ID_IPC1];
		next_extVector[VB_IPC2] = rawSync[ID_IPC2];
		next_extVector[VB_IPC3] = rawSync[ID_IPC3];
		next_extVector[VB_ATIM +: 4] = rawSync[ID_ATIM +: 4];
		next_extVector[VB_SEC] = rawSync[ID_SEC];
		next_extVector[VB_STREAM] = rawSync[ID_STREAM];
		next_extVector[VB_FCONV] = rawSync[ID_FCONV];
		next_extVector[VB_USB] = rawSync[ID_USB];
		next_extVector[VB_HDMI] = rawSync[ID_HDMI];
		next_extVector[VB_DMA_S] = rawSync[ID_DMA_S];
		next_extVector[VB_DMA_NS] = rawSync[ID_DMA_NS];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			coreIrq <= '0;
			extVector <= '0;
			coreDebugIrq <= 1'b0;
		end else begin
			coreIrq <= next_coreIrq;
			extVector <= next_extVector;
			coreDebugIrq <= dbgSync;
		end
	end

	// Local memories: low half instruction, high half data
	logic [63:0] instrMem [MEM_WORDS];
	logic [63:0] dataMem [MEM_WORDS];
	adim_state_e state;
	logic [ADDR_WIDTH-1:0] addrHold;
	logic okHold;
	wire wrPick = awvalid && (state == ST_IDLE);
	wire rdPick = arvalid && !awvalid && (state == ST_IDLE);
	wire [MEM_AW-1:0] wIdx = addrHold[MEM_AW+2:3];
	wire [MEM_AW-1:0] rIdx = araddr[MEM_AW+2:3];
	wire wFire = (state == ST_WRITE) && wvalid;
	wire wDoIt = wFire && okHold;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			addrHold <= '0;
			okHold <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
			rlast <= 1'b0;
		end else begin
			awready <= 1'b0;
			arready <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (wrPick) begin
						addrHold <= awaddr;
						okHold <= accessOk(awaddr, awsize);
						awready <= 1'b1;
						wready <= 1'b1;
						state <= ST_WRITE;
					end else if (rdPick) begin
						arready <= 1'b1;
						rvalid <= 1'b1;
						rlast <= 1'b1;
						rresp <= accessOk(araddr, arsize) ? RESP_OKAY : RESP_SLVERR;
						rdata <= !accessOk(araddr, arsize) ? 64'h0 :
							araddr[DATA_BIT] ? dataMem[rIdx] : instrMem[rIdx];
						state <= ST_READ;
					end
				end
				ST_WRITE: begin
					if (wvalid) begin
						wready <= 1'b0;
						bvalid <= 1'b1;
						bresp <= okHold ? RESP_OKAY : RESP_SLVERR;
						state <= ST_WRESP;
					end
				end
				ST_WRESP: begin
					if (bready) begin
						bvalid <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_READ: begin
					if (rready) begin
						rvalid <= 1'b0;
						rlast <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Byte-lane merge, one writer for both memories
	logic [63:0] curWord, mergedWord;
	assign curWord = addrHold[DATA_BIT] ? dataMem[wIdx] : instrMem[wIdx];
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gLane
			assign mergedWord[8*g +: 8] = wstrb[g] ? wdata[8*g +: 8] : curWord[8*g +: 8];
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (wDoIt) begin
			if (addrHold[DATA_BIT])
				dataMem[wIdx] <= mergedWord;
			else
				instrMem[wIdx] <= mergedWord;
		end
	end

	// Source-side checks wait until the sync chain holds no reset values
	logic [1:0] warmCnt;
	wire settled = (warmCnt == SYNC_LAT);
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			warmCnt <= 2'h0;
		else if (!settled)
			warmCnt <= warmCnt + 2'h1;
	end

	AST_NMI_OR: assert property (@(posedge clk) disable iff (rst)
		(|nmiSync) |=> coreIrq[ID_NMI] && extVector[VB_NMI]) else $error("NMI not raised");
	AST_NMI_LOW: assert property (@(posedge clk) disable iff (rst)
		(nmiSync == '0) |=> !coreIrq[ID_NMI]) else $error("NMI raised without source");
	AST_DEBUG: assert property (@(posedge clk) disable iff (rst)
		dbgSync |=> coreDebugIrq) else $error("Debug line not forwarded");
	AST_TIMERS: assert property (@(posedge clk) disable iff (rst)
		settled |-> coreIrq[ID_TIM1] == $past(timer1Irq, SYNC_LAT) &&
		coreIrq[ID_TIM0] == $past(timer0Irq, SYNC_LAT)) else $error("Timer mapping wrong");
	AST_IPC3: assert property (@(posedge clk) disable iff (rst)
		settled |-> extVector[VB_IPC3] == $past(ipcIrq[3], SYNC_LAT)) else $error("IPC3 vector bit wrong");
	AST_ATIM: assert property (@(posedge clk) disable iff (rst)
		settled |-> extVector[VB_ATIM +: 4] == $past(audioTimerIrq, SYNC_LAT)) else $error("Audio timer bits wrong");
	AST_SEC: assert property (@(posedge clk) disable iff (rst)
		settled |-> extVector[VB_SEC] == $past(|securityIrq, SYNC_LAT)) else $error("Security bit wrong");
	AST_USB: assert property (@(posedge clk) disable iff (rst)
		settled |-> extVector[VB_USB] == $past(usbAudioIrq | usbCtrlIrq, SYNC_LAT) &&
		extVector[VB_HDMI] == $past(hdmiSecIrq | hdmiNsIrq, SYNC_LAT)) else $error("Merged bits wrong");
	AST_DMA: assert property (@(posedge clk) disable iff (rst)
		settled |-> extVector[VB_DMA_NS] == $past(audio_dma_nonsecure_irq, SYNC_LAT) &&
		extVector[VB_DMA_S] == $past(audio_dma_secure_irq, SYNC_LAT)) else $error("DMA bit wrong");
	AST_INSTR_TIGHT_MEM_NARROW: assert property (@(posedge clk) disable iff (rst)
		rdPick && !araddr[DATA_BIT] && arsize == SIZE_8 |=> rvalid && rresp == RESP_SLVERR)
		else $error("Narrow instruction read accepted");
	AST_DATA_TIGHT_MEM_BYTE: assert property (@(posedge clk) disable iff (rst)
		rdPick && araddr[DATA_BIT] && arsize == SIZE_8 |=> rresp == RESP_OKAY)
		else $error("Byte data read refused");
	AST_LEVEL: assert property (@(posedge clk) disable iff (rst)
		ipcIrq[0] [*4] |-> coreIrq[ID_IPC0]) else $error("Held level not pending");
endmodule

// File: bench/adim_axi_master.sv
`timescale 1ns/1ps
module adim_axi_master
	import adim_pkg::*;
(
	// Clock
	input wire logic clk,
	// Requests
	output logic awvalid,
	output logic [ADDR_WIDTH-1:0] awaddr,
	output logic [2:0] awsize,
	output logic wvalid,
	output logic [63:0] wdata,
	output logic [7:0] wstrb,
	output logic bready,
	output logic arvalid,
	output logic [ADDR_WIDTH-1:0] araddr,
	output logic [2:0] arsize,
	output logic rready,
	// Answers
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [1:0] bresp,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [63:0] rdata,
	input wire logic [1:0] rresp
);
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, awsize, arsize, wdata, wstrb} = '0;
	end
	// Single-beat write, request held until accepted
	task automatic wr(input logic [15:0] a, input logic [2:0] s, input logic [63:0] d, input logic [7:0] st,
		output logic [1:0] r);
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		awsize <= s;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= st;
		bready <= 1'b1;
		do @(posedge clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		awaddr <= ~a;
		wdata <= ~d;
		while (bvalid !== 1'b1) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask
	// Single-beat read
	task automatic rd(input logic [15:0] a, input logic [2:0] s, output logic [63:0] d, output logic [1:0] r);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		arsize <= s;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		while (rvalid !== 1'b1) @(posedge clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

// File: bench/adim_top_tb.sv
`timescale 1ns/1ps
module adim_top_tb
	import adim_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [38:0] src = '0;
	logic [31:0] coreIrq;
	logic coreDebugIrq;
	logic [15:0] extVector;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, rlast;
	logic [15:0] awaddr, araddr;
	logic [2:0] awsize, arsize;
	logic [63:0] wdata, rdata;
	logic [7:0] wstrb;
	logic [1:0] bresp, rresp;
	int fail_count = 0;
	int n_tests = 0;
	always #20 clk = ~clk;
	adim_top dut_u (.nmi_source_bits(src[15:0]), .debugIrq(src[16]), .softIrq(src[17]), .timer0Irq(src[18]),
		.timer1Irq(src[19]), .ipcIrq(src[23:20]), .audioTimerIrq(src[27:24]), .securityIrq(src[30:28]),
		.streamIrq(src[31]), .freqConvIrq(src[32]), .usbAudioIrq(src[33]), .usbCtrlIrq(src[34]),
		.hdmiSecIrq(src[35]), .hdmiNsIrq(src[36]), .audio_dma_secure_irq(src[37]),
		.audio_dma_nonsecure_irq(src[38]), .*);
	adim_axi_master mdl_u (.*);
	function automatic logic [31:0] expIrq(input logic [38:0] v);
		expIrq = '0;
		expIrq[0] = |v[15:0];
		expIrq[1] = v[17];
		expIrq[4:2] = v[22:20];
		expIrq[6:5] = v[19:18];
		expIrq[7] = v[23];
		expIrq[11:8] = v[27:24];
		expIrq[12] = |v[30:28];
		expIrq[14:13] = v[32:31];
		expIrq[15] = v[33] | v[34];
		expIrq[16] = v[35] | v[36];
		expIrq[18:17] = v[38:37];
	endfunction
	task automatic chkVal(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkResp(input string nm, input logic [1:0] e, input logic [1:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Apply a source pattern and check the core side three edges later
	task automatic irqStep(input logic [38:0] v);
		logic [31:0] e;
		@(posedge clk);
		src <= v;
		repeat (3) @(posedge clk);
		#1;
		e = expIrq(v);
		chkVal("coreIrq", e, coreIrq);
		chkVal("extVector", {e[18:12], v[27:24], v[23:20], e[0]}, extVector);
		chkVal("coreDebugIrq", v[16], coreDebugIrq);
	endtask
	// Init a word, write at the tested width (8 to 64 bits), read back whole and at the tested width
	task automatic memStep(input logic r, input logic [1:0] s, input logic m);
		logic [15:0] a;
		logic [63:0] d, q;
		logic [7:0] st;
		logic [1:0] rs;
		logic ok;
		logic [63:0] lm;
		a = {r, 6'h00, 6'($urandom), 3'h0};
		a[2:0] = 3'((($urandom % (8 >> s)) << s) | (m && s != 0));
		ok = !(m && s != 0) && (r || s[1]);
		q = {$urandom, $urandom};
		mdl_u.wr(a & 16'hfff8, SIZE_64, q, 8'hff, rs);
		chkResp("bresp", RESP_OKAY, rs);
		d = {$urandom, $urandom};
		st = 8'(((1 << (1 << s)) - 1) << a[2:0]);
		mdl_u.wr(a, {1'b0, s}, d, st, rs);
		chkResp("bresp", ok ? RESP_OKAY : RESP_SLVERR, rs);
		if (ok) for (int i = 0; i < 8; i++) if (st[i]) q[8*i +: 8] = d[8*i +: 8];
		mdl_u.rd(a & 16'hfff8, SIZE_64, d, rs);
		chkVal("rdata", q, d);
		mdl_u.rd(a, {1'b0, s}, d, rs);
		chkResp("rresp", ok ? RESP_OKAY : RESP_SLVERR, rs);
		for (int i = 0; i < 8; i++) lm[8*i +: 8] = {8{st[i]}};
		if (!ok) chkVal("rdata", '0, d);
		else chkVal("rdata lanes", q & lm, d & lm);
	endtask
	// Every accepted read beat is the last one
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) chkVal("rlast", 64'h1, 64'(rlast));
	end
	initial begin
		void'($urandom(32'h05f9));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		irqStep('0);
		irqStep('1);
		for (int i = 0; i < 39; i++) irqStep(39'h1 << i);
		repeat (30) irqStep(39'({$urandom, $urandom}));
		for (int k = 0; k < 40; k++) begin
			logic [3:0] c;
			c = 4'(k < 16 ? k : $urandom);
			memStep(c[3], c[2:1], c[0]);
		end
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end
endmodule
